/* wtbtm_pkg.sv */
// Constants for the wake-up timer, battery monitor and temperature sensor block.
// ==========================================================================
// Overview of operation
// RULE1: Temperature sensor powers on when ADC input is 000 or test bus selects it.
// RULE2: Host selects input 000, reference 00, range, offset enable, starts, reads result.
// RULE3: Two-bit range field picks one of four temperature scales for the sensor.
// RULE4: Offset enable clear with range 10 gives absolute kelvin test mode.
// RULE5: With digital offset enabled, the offset register is added to ADC result.
// RULE6: With trim enabled, the trim field is applied to the analog sensor.
// RULE7: Host converts result as value times LSB plus lowest range temperature.
// RULE8: Battery monitor runs only while its enable bit in register 07h is set.
// RULE9: Five-bit battery level readable while enabled; upper three bits read zero.
// RULE10: Battery code means 1.7 V plus 50 mV per count, saturating at 31.
// RULE11: Level below threshold raises the battery interrupt on irq_n when enabled.
// RULE12: Battery interrupt only after four consecutive low measurements.
// RULE13: Monitor powered once per second for about 250 us per measurement.
// RULE14: Battery monitor enabled in sleep turns on the low-frequency RC oscillator; the code keeps it off while crystal select is set.
// RULE15: Host reads both interrupt status registers to find the source.
// RULE16: Wake timer enabled at sleep entry counts period on the 32.768 kHz clock.
// RULE17: Wake period is 4 times mantissa times two to exponent over 32.768 ms.
// RULE18: A two-bit fine divider field sits beside exponent and mantissa.
// RULE19: Enabled wake interrupt on expiry drives irq_n low and leaves sleep.
// RULE20: Disabled wake interrupt: expiry does not change the operating state.
// RULE21: Sixteen-bit wake count readable at any time, high byte first.
// RULE22: Crystal select makes GPIO0 the 32 kHz crystal pin and clock source.
// RULE23: Conversion start bit clears itself at the end of conversion.
// RULE24: Wake timer restarts from zero after each expiry while enabled.
package wtbtm_pkg;
  // ==========================================================================
  // Register offsets.
  localparam logic [6:0] ADDR_IRQ_STATUS2 = 7'h04;
  localparam logic [6:0] ADDR_IRQ_ENABLE2 = 7'h06;
  localparam logic [6:0] ADDR_OP_CTRL1    = 7'h07;
  localparam logic [6:0] ADDR_ADC_CFG     = 7'h0f;
  localparam logic [6:0] ADDR_ADC_VALUE   = 7'h11;
  localparam logic [6:0] ADDR_TEMP_CTRL   = 7'h12;
  localparam logic [6:0] ADDR_TEMP_OFFS   = 7'h13;
  localparam logic [6:0] ADDR_WAKE_EXP    = 7'h14;
  localparam logic [6:0] ADDR_WAKE_MANT_H = 7'h15;
  localparam logic [6:0] ADDR_WAKE_MANT_L = 7'h16;
  localparam logic [6:0] ADDR_WAKE_CNT_H  = 7'h17;
  localparam logic [6:0] ADDR_WAKE_CNT_L  = 7'h18;
  localparam logic [6:0] ADDR_BAT_THRESH  = 7'h1a;
  localparam logic [6:0] ADDR_BAT_LEVEL   = 7'h1b;
  // ==========================================================================
  // Field positions.
  localparam int BIT_WAKE_IRQ   = 3;
  localparam int BIT_BAT_IRQ    = 2;
  localparam int BIT_BAT_EN     = 6;
  localparam int BIT_WAKE_EN    = 5;
  localparam int BIT_XTAL_SEL   = 4;
  localparam int BIT_ADC_START  = 7;
  localparam int BIT_SHIFT_EN   = 5;
  localparam int BIT_TRIM_EN    = 4;
  // ==========================================================================
  // Reset values, fixed field codes, debounce count and SPI frame length.
  localparam logic [7:0] RST_TEMP_CTRL  = 8'h20;
  localparam logic [4:0] RST_BAT_THRESH = 5'h14;
  localparam logic [1:0] RANGE_KELVIN   = 2'h2;
  localparam logic [2:0] ADC_SEL_TEMP   = 3'h0;
  localparam logic [2:0] DEBOUNCE_COUNT = 3'h4;
  localparam int SPI_FRAME_BITS = 16;
  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int BAT_PERIOD_US    = 1000000;
  localparam int BAT_ON_US        = 250;
  localparam int BAT_PERIOD_CYC   = BAT_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int BAT_ON_CYC       = BAT_ON_US * 1000 / CLK_PERIOD_NS;
  localparam int WAKE_BASE_SHIFT  = 2;
endpackage

/* wtbtm_wake_counter.sv */
// Wake-up timer prescaler and mantissa counter on low-frequency ticks.
`timescale 1ns/1ns
module wtbtm_wake_counter
  import wtbtm_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        run_in,
  input  wire logic        tick_in,
  input  wire logic [3:0]  exp_in,
  input  wire logic [1:0]  div_in,
  input  wire logic [15:0] mant_in,
  output logic      [15:0] count_out,
  output logic             expire_out
);
  logic [17:0] pre_reg;
  logic [4:0]  shift_next;
  logic        pre_wrap;

  // The fine divider shortens the prescale span, down to one tick at the least.
  always_comb begin
    shift_next = 5'(exp_in) + 5'(WAKE_BASE_SHIFT); // RULE17
    shift_next = (shift_next > 5'(div_in)) ? shift_next - 5'(div_in) : 5'h00; // RULE18
    pre_wrap   = (pre_reg == ((18'h00001 << shift_next) - 18'h00001));
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_reg    <= 18'h00000;
      count_out  <= 16'h0000;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (!run_in) begin
        pre_reg   <= 18'h00000;
        count_out <= 16'h0000;
      end else if (tick_in) begin // RULE16
        pre_reg <= pre_wrap ? 18'h00000 : pre_reg + 18'h00001;
        if (pre_wrap && mant_in != 16'h0000) begin
          if (count_out + 16'h0001 == mant_in) begin
            count_out  <= 16'h0000; // RULE24
            expire_out <= 1'b1;
          end else begin
            count_out <= count_out + 16'h0001;
          end
        end
      end
    end
  end
endmodule

/* wtbtm_top.sv */
// Wake-up timer, battery monitor and temperature sensor control with SPI registers.
`timescale 1ns/1ns
module wtbtm_top
  import wtbtm_pkg::*;
#(
  parameter int BAT_PERIOD = BAT_PERIOD_CYC,
  parameter int BAT_ON     = BAT_ON_CYC
)
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       sclk_in,
  input  wire logic       sel_n_in,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  output logic            irq_n_out,
  input  wire logic       sleep_in,
  input  wire logic       lf_rc_tick_in,
  input  wire logic       lf_xtal_in,
  input  wire logic       test_bus_temp_in,
  output logic            lf_rc_enable_out,
  output logic            gpio0_xtal_mode_out,
  output logic            wake_request_out,
  output logic            temp_sensor_on_out,
  output logic [1:0]      temp_range_out,
  output logic            temp_absolute_out,
  output logic [3:0]      temp_trim_out,
  output logic [2:0]      adc_sel_out,
  output logic [1:0]      adc_ref_out,
  output logic [1:0]      adc_gain_out,
  output logic            adc_start_out,
  input  wire logic       adc_done_in,
  input  wire logic [7:0] adc_data_in,
  output logic            bat_power_out,
  input  wire logic [4:0] bat_level_in
);
  // ==========================================================================
  // Elaboration check.
  if (BAT_ON < 1 || BAT_ON >= BAT_PERIOD) begin : g_bad_timing
    $error("Battery on-time must be at least one cycle and below the period.");
  end

  // ==========================================================================
  // Register storage.
  logic [1:0]  irq_en_reg;
  logic [1:0]  irq_stat_reg;
  logic [2:0]  op_ctrl_reg;
  logic [7:0]  adc_cfg_reg;
  logic [7:0]  adc_value_reg;
  logic [7:0]  temp_ctrl_reg;
  logic [7:0]  temp_offs_reg;
  logic [5:0]  wake_exp_reg;
  logic [15:0] wake_mant_reg;
  logic [7:0]  wake_low_snap_reg;
  logic [4:0]  bat_thresh_reg;
  logic [4:0]  bat_level_reg;
  logic bat_en;
  logic wake_en;
  logic xtal_sel;
  assign bat_en   = op_ctrl_reg[2];
  assign wake_en  = op_ctrl_reg[1];
  assign xtal_sel = op_ctrl_reg[0];

  // ==========================================================================
  // SPI slave: write flag, 7-bit address, 8 data bits, MSB first.
  logic [4:0]  bit_cnt_reg;
  logic [15:0] rx_reg;
  logic [7:0]  tx_reg;
  logic        sclk_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        addr_done;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [6:0]  rx_addr;
  logic [7:0]  wr_data;
  logic [15:0] wake_count;
  logic        wake_expire;

  assign sclk_rise = sclk_in && !sclk_reg && !sel_n_in;
  assign sclk_fall = !sclk_in && sclk_reg && !sel_n_in;
  assign addr_done = sclk_rise && bit_cnt_reg == 5'h07;
  assign rx_addr   = {rx_reg[5:0], sdi_in};
  assign rd_strobe = addr_done && !rx_reg[6];
  assign wr_data   = {rx_reg[6:0], sdi_in};
  assign wr_strobe = sclk_rise && bit_cnt_reg == 5'(SPI_FRAME_BITS - 1) && rx_reg[14];

  function automatic logic [7:0] read_mux(input logic [6:0] a);
    case (a)
      ADDR_IRQ_STATUS2: read_mux = {4'h0, irq_stat_reg, 2'h0};
      ADDR_IRQ_ENABLE2: read_mux = {4'h0, irq_en_reg, 2'h0};
      ADDR_OP_CTRL1:    read_mux = {1'b0, op_ctrl_reg, 4'h0};
      ADDR_ADC_CFG:     read_mux = adc_cfg_reg;
      ADDR_ADC_VALUE:   read_mux = adc_value_reg;
      ADDR_TEMP_CTRL:   read_mux = temp_ctrl_reg;
      ADDR_TEMP_OFFS:   read_mux = temp_offs_reg;
      ADDR_WAKE_EXP:    read_mux = {2'h0, wake_exp_reg};
      ADDR_WAKE_MANT_H: read_mux = wake_mant_reg[15:8];
      ADDR_WAKE_MANT_L: read_mux = wake_mant_reg[7:0];
      ADDR_WAKE_CNT_H:  read_mux = wake_count[15:8];
      ADDR_WAKE_CNT_L:  read_mux = wake_low_snap_reg; // RULE21
      ADDR_BAT_THRESH:  read_mux = {3'h0, bat_thresh_reg};
      ADDR_BAT_LEVEL:   read_mux = {3'h0, bat_level_reg}; // RULE9
      default:          read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_reg    <= 1'b0;
      bit_cnt_reg <= 5'h00;
      rx_reg      <= 16'h0000;
      tx_reg      <= 8'h00;
      sdo_out     <= 1'b0;
      sdo_oe_out  <= 1'b0;
    end else begin
      sclk_reg   <= sclk_in;
      sdo_oe_out <= !sel_n_in;
      if (sel_n_in) begin
        bit_cnt_reg <= 5'h00;
        sdo_out     <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rx_reg <= {rx_reg[14:0], sdi_in};
          if (bit_cnt_reg != 5'(SPI_FRAME_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        if (rd_strobe) begin
          tx_reg <= read_mux(rx_addr);
        end else if (sclk_fall && bit_cnt_reg >= 5'h08) begin
          sdo_out <= tx_reg[7];
          tx_reg  <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Reading the high count byte freezes the low byte so the pair is coherent.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_low_snap_reg <= 8'h00;
    end else if (rd_strobe && rx_addr == ADDR_WAKE_CNT_H) begin
      wake_low_snap_reg <= wake_count[7:0]; // RULE21
    end
  end

  // ==========================================================================
  // Writable configuration.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_en_reg     <= 2'h0;
      op_ctrl_reg    <= 3'h0;
      temp_ctrl_reg  <= RST_TEMP_CTRL;
      temp_offs_reg  <= 8'h00;
      wake_exp_reg   <= 6'h00;
      wake_mant_reg  <= 16'h0000;
      bat_thresh_reg <= RST_BAT_THRESH;
    end else if (wr_strobe) begin
      case (rx_reg[13:7])
        ADDR_IRQ_ENABLE2: irq_en_reg     <= wr_data[BIT_WAKE_IRQ:BIT_BAT_IRQ];
        ADDR_OP_CTRL1:    op_ctrl_reg    <= wr_data[BIT_BAT_EN:BIT_XTAL_SEL];
        ADDR_TEMP_CTRL:   temp_ctrl_reg  <= wr_data;
        ADDR_TEMP_OFFS:   temp_offs_reg  <= wr_data;
        ADDR_WAKE_EXP:    wake_exp_reg   <= wr_data[5:0];
        ADDR_WAKE_MANT_H: wake_mant_reg  <= {wr_data, wake_mant_reg[7:0]};
        ADDR_WAKE_MANT_L: wake_mant_reg  <= {wake_mant_reg[15:8], wr_data};
        ADDR_BAT_THRESH:  bat_thresh_reg <= wr_data[4:0];
        default:          irq_en_reg     <= irq_en_reg;
      endcase
    end
  end

  // ==========================================================================
  // ADC configuration, conversion handshake and offset result.
  logic adc_busy;
  assign adc_busy = adc_cfg_reg[BIT_ADC_START];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      adc_cfg_reg   <= 8'h00;
      adc_start_out <= 1'b0;
      adc_value_reg <= 8'h00;
    end else begin
      adc_start_out <= 1'b0;
      if (wr_strobe && rx_reg[13:7] == ADDR_ADC_CFG) begin
        // A write cannot abort a conversion, nor hide one that ends in the same cycle.
        adc_cfg_reg   <= {(adc_busy && !adc_done_in) || (wr_data[7] && !adc_busy), wr_data[6:0]};
        adc_start_out <= wr_data[BIT_ADC_START] && !adc_busy;
      end else if (adc_busy && adc_done_in) begin
        adc_cfg_reg[BIT_ADC_START] <= 1'b0; // RULE23
      end
      if (adc_busy && adc_done_in) begin
        adc_value_reg <= temp_ctrl_reg[BIT_SHIFT_EN] ?
                         adc_data_in + temp_offs_reg : adc_data_in; // RULE5
      end
    end
  end

  // ==========================================================================
  // Temperature sensor analog controls.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      temp_sensor_on_out <= 1'b0;
      temp_range_out     <= 2'h0;
      temp_absolute_out  <= 1'b0;
      temp_trim_out      <= 4'h0;
      adc_sel_out        <= 3'h0;
      adc_ref_out        <= 2'h0;
      adc_gain_out       <= 2'h0;
    end else begin
      temp_sensor_on_out <= adc_cfg_reg[6:4] == ADC_SEL_TEMP || test_bus_temp_in; // RULE1
      temp_range_out     <= temp_ctrl_reg[7:6]; // RULE3
      temp_absolute_out  <= !temp_ctrl_reg[BIT_SHIFT_EN]
                            && temp_ctrl_reg[7:6] == RANGE_KELVIN; // RULE4
      temp_trim_out      <= temp_ctrl_reg[BIT_TRIM_EN] ? temp_ctrl_reg[3:0] : 4'h0; // RULE6
      adc_sel_out        <= adc_cfg_reg[6:4];
      adc_ref_out        <= adc_cfg_reg[3:2];
      adc_gain_out       <= adc_cfg_reg[1:0];
    end
  end

  // ==========================================================================
  // Battery monitor: periodic power window and debounced threshold check.
  logic [31:0] bat_cyc_reg;
  logic [2:0]  low_cnt_reg;
  logic        bat_sample;
  logic        bat_low_event;
  assign bat_sample    = bat_en && bat_cyc_reg == 32'(BAT_ON - 1);
  assign bat_low_event = bat_sample && bat_level_in < bat_thresh_reg
                         && low_cnt_reg == DEBOUNCE_COUNT - 3'h1;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bat_cyc_reg   <= 32'h0000_0000;
      bat_power_out <= 1'b0;
    end else if (!bat_en) begin
      bat_cyc_reg   <= 32'h0000_0000; // RULE8
      bat_power_out <= 1'b0;
    end else begin
      bat_cyc_reg   <= (bat_cyc_reg == 32'(BAT_PERIOD - 1)) ? 32'h0000_0000
                       : bat_cyc_reg + 32'h0000_0001;
      bat_power_out <= bat_cyc_reg < 32'(BAT_ON - 1)
                       || bat_cyc_reg == 32'(BAT_PERIOD - 1); // RULE13
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bat_level_reg <= 5'h00;
      low_cnt_reg   <= 3'h0;
    end else if (!bat_en) begin
      low_cnt_reg <= 3'h0;
    end else if (bat_sample) begin
      bat_level_reg <= bat_level_in; // RULE9 RULE10
      if (bat_level_in < bat_thresh_reg) begin // RULE11
        low_cnt_reg <= (low_cnt_reg == DEBOUNCE_COUNT) ? low_cnt_reg
                       : low_cnt_reg + 3'h1; // RULE12
      end else begin
        low_cnt_reg <= 3'h0;
      end
    end
  end

  // ==========================================================================
  // Wake timer on the selected low-frequency source.
  logic xtal_reg;
  logic lf_tick;
  logic sleep_reg;
  logic wake_run_reg;
  assign lf_tick = xtal_sel ? (lf_xtal_in && !xtal_reg) : lf_rc_tick_in; // RULE22

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xtal_reg     <= 1'b0;
      sleep_reg    <= 1'b0;
      wake_run_reg <= 1'b0;
    end else begin
      xtal_reg  <= lf_xtal_in;
      sleep_reg <= sleep_in;
      if (!wake_en) begin
        wake_run_reg <= 1'b0;
      end else if (sleep_in && !sleep_reg) begin
        wake_run_reg <= 1'b1; // RULE16
      end
    end
  end
  wtbtm_wake_counter u_wake_counter (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .run_in      (wake_run_reg),
    .tick_in     (lf_tick),
    .exp_in      (wake_exp_reg[5:2]),
    .div_in      (wake_exp_reg[1:0]),
    .mant_in     (wake_mant_reg),
    .count_out   (wake_count),
    .expire_out  (wake_expire)
  );
  // ==========================================================================
  // Interrupt status, pin and sleep exit; a new event beats a clear-on-read.
  logic stat_read;
  assign stat_read = rd_strobe && rx_addr == ADDR_IRQ_STATUS2;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg[1] <= wake_expire || (irq_stat_reg[1] && !stat_read);
      irq_stat_reg[0] <= bat_low_event || (irq_stat_reg[0] && !stat_read); // RULE12
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_n_out           <= 1'b1;
      wake_request_out    <= 1'b0;
      lf_rc_enable_out    <= 1'b0;
      gpio0_xtal_mode_out <= 1'b0;
    end else begin
      irq_n_out <= !(|(irq_stat_reg & irq_en_reg)); // RULE11 RULE19
      if (wake_expire && irq_en_reg[1]) begin
        wake_request_out <= 1'b1; // RULE19
      end else if (!sleep_in) begin
        wake_request_out <= 1'b0; // RULE20
      end
      lf_rc_enable_out    <= sleep_in && !xtal_sel && (bat_en || wake_en); // RULE14
      gpio0_xtal_mode_out <= xtal_sel; // RULE22
    end
  end

  // ==========================================================================
  // Checks.
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_temp_sensor_on: assert property ( // RULE1
    (adc_cfg_reg[6:4] == 3'h0) |=> temp_sensor_on_out)
    else $error("Temperature sensor not powered for its ADC input.");
  chk_adc_self_clear: assert property ( // RULE23
    (adc_busy && adc_done_in && !wr_strobe) |=> !adc_busy)
    else $error("Conversion start bit did not clear at conversion end.");
  chk_offset_add: assert property ( // RULE5
    (adc_busy && adc_done_in && temp_ctrl_reg[5])
    |=> adc_value_reg == 8'($past(adc_data_in) + $past(temp_offs_reg)))
    else $error("Digital offset not added to ADC result.");
  chk_bat_disabled: assert property ( // RULE8
    !bat_en [*2] |-> !bat_power_out)
    else $error("Battery monitor powered while disabled.");
  chk_bat_window: assert property ( // RULE13
    (bat_en && bat_cyc_reg == 32'(BAT_ON)) |=> !bat_power_out)
    else $error("Battery monitor powered outside its window.");
  chk_bat_debounce: assert property ( // RULE12
    $rose(irq_stat_reg[0]) |-> low_cnt_reg == DEBOUNCE_COUNT)
    else $error("Battery interrupt without four low measurements.");
  chk_irq_pin: assert property ( // RULE11
    (|(irq_stat_reg & irq_en_reg)) |=> !irq_n_out)
    else $error("Interrupt pin not driven low for an enabled source.");
  chk_wake_exit: assert property ( // RULE19
    (wake_expire && irq_en_reg[1]) |=> wake_request_out ##1 !irq_n_out)
    else $error("Enabled wake expiry did not leave sleep and interrupt.");
  chk_wake_quiet: assert property ( // RULE20
    (wake_expire && !irq_en_reg[1] && !wake_request_out) |=> !wake_request_out)
    else $error("Wake expiry changed state with its interrupt disabled.");
  chk_rc_on_sleep: assert property ( // RULE14
    (sleep_in && bat_en && !xtal_sel) |=> lf_rc_enable_out)
    else $error("RC oscillator not enabled for battery monitor in sleep.");
  cov_wake_expire: cover property (wake_expire && irq_en_reg[1]);
  cov_bat_irq:     cover property ($rose(irq_stat_reg[0]));
  cov_adc_done:    cover property (adc_busy && adc_done_in);
  cov_spi_write:   cover property (wr_strobe);
endmodule

/* wtbtm_host.sv */
// Host microcontroller model that runs SPI frames toward the device registers.
`timescale 1ns/1ns
module wtbtm_host (
  input  wire logic core_clk_in,
  output logic      sclk_out,
  output logic      sel_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // ==========================================================================
  // Frame task.
  // Clock phases last three core cycles so the sampled edges are always seen.
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rdata);
    rdata = 8'h00;
    @(posedge core_clk_in) sel_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge core_clk_in) sclk_out <= 1'b0;
      sdi_out <= frame[i];
      repeat (3) @(posedge core_clk_in);
      if (i < 8) rdata = {rdata[6:0], sdo_in};
      sclk_out <= 1'b1;
      repeat (2) @(posedge core_clk_in);
    end
    // The data line is turned over once released so no stale bit lingers.
    @(posedge core_clk_in) sclk_out <= 1'b0;
    sel_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    @(posedge core_clk_in);
  endtask
endmodule

/* test_wtbtm_top.sv */
// Self-checking testbench for the wake timer, battery monitor and temperature block.
`timescale 1ns/1ns
module test_wtbtm_top;
  import wtbtm_pkg::*;
  logic       core_clk_in, resetn_in, sclk, sel_n, sdi, sdo, irq_n, sleep, tick, xtal;
  logic       tbus, rc_en, xmode, wake_req, ts_on, absol, start, done, bpow, oe;
  logic [1:0] range, aref, again;
  logic [3:0] trim;
  logic [2:0] tk, asel;
  logic [4:0] blevel;
  logic [7:0] adata, rd;
  int         mismatches, checks, cyc, acnt, starts, n;
  wtbtm_top #(.BAT_PERIOD(200), .BAT_ON(20)) DUT (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .sclk_in(sclk), .sel_n_in(sel_n), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_oe_out(oe), .irq_n_out(irq_n), .sleep_in(sleep), .lf_rc_tick_in(tick),
    .lf_xtal_in(xtal), .test_bus_temp_in(tbus), .lf_rc_enable_out(rc_en),
    .gpio0_xtal_mode_out(xmode), .wake_request_out(wake_req), .temp_sensor_on_out(ts_on),
    .temp_range_out(range), .temp_absolute_out(absol), .temp_trim_out(trim),
    .adc_sel_out(asel), .adc_ref_out(aref), .adc_gain_out(again), .adc_start_out(start),
    .adc_done_in(done), .adc_data_in(adata), .bat_power_out(bpow), .bat_level_in(blevel));
  wtbtm_host host (.core_clk_in(core_clk_in), .sclk_out(sclk), .sel_n_out(sel_n),
    .sdi_out(sdi), .sdo_in(sdo));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ==========================================================================
  // Low-frequency ticks, a slow converter and the run limit.
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    tk <= tk + 3'h1;
    tick <= (tk == 3'h7);
    xtal <= tk[2];
    done <= (acnt == 1);
    acnt <= start ? 150 : (acnt > 0 ? acnt - 1 : 0);
    if (start) starts <= starts + 1;
    if (cyc >= 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Access and compare tasks.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, rd);
  endtask
  task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_pin(input string what, input logic exp, input logic got);
    check_reg(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({1'b0, a, 8'h00}, rd);
    check_reg($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic wait_pin(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 1000) begin
      @(posedge core_clk_in);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {resetn_in, sleep, tbus, tk, tick, xtal, done, cyc, acnt, starts} = '0;
    {mismatches, checks} = '0;
    blevel = 5'h1f;
    adata = 8'h30;
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    check_pin("sdo enable", 1'b0, oe);
    rdchk(7'h12, 8'h20);
    rdchk(7'h1a, 8'h14);
    rdchk(7'h16, 8'h00);
    rdchk(7'h7f, 8'h00);
    wr(7'h1b, 8'hff);
    rdchk(7'h1b, 8'h00);
    $display("test registers done");
    wr(7'h0f, 8'h1b);
    check_reg("adc config", 8'h1b, {1'b0, asel, aref, again});
    check_pin("sensor on", 1'b0, ts_on);
    tbus <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    check_pin("sensor on", 1'b1, ts_on);
    tbus <= 1'b0;
    wr(7'h0f, 8'h00);
    check_pin("sensor on", 1'b1, ts_on);
    for (int r = 0; r < 4; r++) begin
      wr(7'h12, {r[1:0], 6'h20});
      check_reg("range", {6'h00, r[1:0]}, {6'h00, range});
      check_pin("absolute", 1'b0, absol);
    end
    wr(7'h12, 8'h80);
    check_pin("absolute", 1'b1, absol);
    wr(7'h12, 8'h1b);
    check_reg("trim", 8'h0b, {4'h0, trim});
    wr(7'h12, 8'h0b);
    check_reg("trim", 8'h00, {4'h0, trim});
    wr(7'h12, 8'h20);
    wr(7'h13, 8'h05);
    wr(7'h0f, 8'h80);
    rdchk(7'h0f, 8'h80);
    repeat (150) @(posedge core_clk_in);
    rdchk(7'h0f, 8'h00);
    rdchk(7'h11, 8'h35);
    check_reg("half degrees", 8'hb5, rd - 8'h80);
    check_reg("starts", 8'h01, starts[7:0]);
    $display("test temperature done");
    blevel <= 5'h10;
    wr(7'h06, 8'h04);
    wr(7'h07, 8'h40);
    check_pin("bat power", 1'b1, bpow);
    repeat (560) @(posedge core_clk_in);
    check_pin("irq", 1'b1, irq_n);
    check_pin("bat power", 1'b0, bpow);
    wait_pin(irq_n, 1'b0);
    check_pin("irq", 1'b0, irq_n);
    rdchk(7'h1b, 8'h10);
    rdchk(7'h04, 8'h04);
    check_pin("irq", 1'b1, irq_n);
    wr(7'h07, 8'h00);
    $display("test battery done");
    wr(7'h16, 8'h03);
    wr(7'h06, 8'h08);
    wr(7'h07, 8'h20);
    sleep <= 1'b1;
    wait_pin(wake_req, 1'b1);
    @(posedge core_clk_in);
    check_pin("rc on", 1'b1, rc_en);
    check_pin("period", 1'b1, n >= 85 && n <= 110);
    check_pin("irq", 1'b0, irq_n);
    rdchk(7'h17, 8'h00);
    rdchk(7'h04, 8'h08);
    repeat (100) @(posedge core_clk_in);
    rdchk(7'h04, 8'h08);
    sleep <= 1'b0;
    wr(7'h06, 8'h00);
    sleep <= 1'b1;
    repeat (250) @(posedge core_clk_in);
    check_pin("wake", 1'b0, wake_req);
    check_pin("irq", 1'b1, irq_n);
    wr(7'h07, 8'h30);
    check_pin("xtal mode", 1'b1, xmode);
    check_pin("rc on", 1'b0, rc_en);
    $display("test wake timer done");
    give_verdict();
  end
endmodule
